// ===== rtl/xdp_pkg.sv
/*
 Shared constants and types for the dummy-cycle and drive-strength
 parameter words block.
 Assumes a single 20 MHz clock and word numbers counted from one.
*/
package xdp_pkg;

	// word numbers inside the register-map parameter table
	localparam logic [7:0] XDP_WORD_DUMMY = 8'h0a;
	localparam logic [7:0] XDP_WORD_DRV_VOL = 8'h0b;
	localparam logic [7:0] XDP_WORD_DRV_NVOL = 8'h0c;
	localparam logic [7:0] XDP_WORD_DRV_TYPE = 8'h0d;

	// dummy-cycle word: five entries for 10, 8, 6, 4, 2 cycles
	localparam int XDP_DUMMY_ENTRIES = 5;
	localparam int XDP_DUMMY_FLAG_TOP = 31;
	localparam int XDP_DUMMY_PAT_TOP = 30;
	localparam int XDP_DUMMY_STRIDE = 6;
	localparam int XDP_DUMMY_PAT_BITS = 5;
	localparam logic [2:0] XDP_DUMMY_MAX_WIDTH = 3'h5;
	localparam int XDP_DUMMY_RSVD_TOP = 1;

	// driver-strength locator words
	localparam int XDP_LOC_WIDTH_TOP = 31;
	localparam int XDP_LOC_WIDTH_BOT = 30;
	localparam int XDP_LOC_BYTE_SEL = 29;
	localparam int XDP_LOC_MSB_TOP = 28;
	localparam int XDP_LOC_MSB_BOT = 25;
	localparam int XDP_LOC_ADDR_TOP = 24;
	localparam int XDP_LOC_ADDR_BOT = 17;
	localparam int XDP_LOC_RSVD_TOP = 16;

	// control width codes
	localparam logic [1:0] XDP_DRV_WIDTH_NONE = 2'h0;
	localparam logic [1:0] XDP_DRV_WIDTH_MAX = 2'h3;

	// driver-type pattern word
	localparam int XDP_DRV_TYPES = 5;
	localparam int XDP_DRV_PAT_TOP = 31;
	localparam int XDP_DRV_PAT_BITS = 3;
	localparam int XDP_DRV_RSVD_TOP = 16;
	// driver type 0 is the 50 ohm strength
	localparam int XDP_DRV_TYPE_50_OHM = 0;

	// values after reset
	localparam logic [31:0] XDP_DATA_RESET = 32'h0000_0000;

	typedef enum logic [0:0] {
		XDP_CAPTURE = 1'b0,
		XDP_READY = 1'b1
	} xdp_state_e;

	typedef struct packed {
		logic [1:0] width;
		logic addr_byte1;
		logic [3:0] msb_pos;
		logic [7:0] reg_addr;
	} xdp_drv_loc_s;

	typedef struct packed {
		logic [4:0] dummy_support;
		logic [24:0] dummy_pattern;
		logic [2:0] dummy_width;
		xdp_drv_loc_s drv_vol;
		xdp_drv_loc_s drv_nvol;
		logic [14:0] drv_pattern;
	} xdp_cfg_s;

	typedef struct packed {
		xdp_state_e state;
		xdp_cfg_s cfg;
		logic rd_valid;
		logic rd_hit;
		logic [31:0] rd_data;
	} xdp_state_s;

endpackage

// ===== rtl/xdp_param_words.sv
/*
 Device-side source of four read-only parameter words: variable dummy
 cycle patterns, volatile and non-volatile driver-strength locators and
 driver-type patterns. The table reader asks for a word by number.
 Assumes the device straps on cfg stay steady and are synchronous to clk.
*/
// Contract
// - Dummy-cycle patterns word is presented as table word ten.
// - Word ten: bit 31 flags 10 cycles, bits 30-26 its pattern.
// - Word ten: bit 25 flags 8 cycles, bits 24-20 its pattern.
// - Word ten: bit 19 flags 6 cycles, bits 18-14 its pattern.
// - Word ten: bit 13 flags 4 cycles, bits 12-8 its pattern.
// - Word ten: bit 7 flags 2 cycles, bits 6-2 its pattern.
// - Narrow dummy patterns sit in low bits, unused upper bits zero.
// - Reserved bits read zero: word ten 1-0, words eleven to thirteen 16:0.
// - Locator bits 31:30 give control width: none, one, two, three bits.
// - Locator bit 29 selects command-address byte 0 or byte 1.
// - Locator bits 28:25 give position of the top control bit.
// - Locator bits 24:17 give the described register's address.
// - Word twelve describes non-volatile control with the same layout.
// - Word thirteen: types 0, 1, 2 at bits 31-29, 28-26, 25-23.
// - Word thirteen: types 3, 4 at bits 22-20, 19-17.
// - Narrow driver-type patterns keep unused upper bits zero.
// - Driver type 0 is the mandatory 50 ohm strength.
module xdp_param_words (
	input wire logic clk,
	input wire logic reset,
	input wire xdp_pkg::xdp_cfg_s cfg,
	input wire logic rd_req,
	input wire logic [7:0] rd_index,
	output logic rd_ready,
	output logic rd_valid,
	output logic rd_hit,
	output logic [31:0] rd_data
);

	xdp_pkg::xdp_state_s st;
	xdp_pkg::xdp_state_s next_st;

	// keep only the low w bits of a dummy pattern
	function automatic logic [4:0] xdp_mask5(
		input logic [4:0] pat,
		input logic [2:0] w
	);
		logic [2:0] wc;
		logic [4:0] m;
		wc = w;
		if (wc > xdp_pkg::XDP_DUMMY_MAX_WIDTH) begin
			wc = xdp_pkg::XDP_DUMMY_MAX_WIDTH;
		end
		m = 5'(5'h1f >> (xdp_pkg::XDP_DUMMY_MAX_WIDTH - wc));
		return pat & m;
	endfunction

	// keep only the low w bits of a driver-type pattern
	function automatic logic [2:0] xdp_mask3(
		input logic [2:0] pat,
		input logic [1:0] w
	);
		logic [2:0] m;
		m = 3'(3'h7 >> (xdp_pkg::XDP_DRV_WIDTH_MAX - w));
		return pat & m;
	endfunction

	// width that governs the driver-type patterns
	function automatic logic [1:0] xdp_drv_width(
		input xdp_pkg::xdp_cfg_s c
	);
		logic [1:0] w;
		w = c.drv_vol.width;
		if (w == xdp_pkg::XDP_DRV_WIDTH_NONE) begin
			w = c.drv_nvol.width;
		end
		return w;
	endfunction

	function automatic logic [31:0] xdp_dummy_word(
		input xdp_pkg::xdp_cfg_s c
	);
		logic [31:0] w;
		logic [4:0] pat;
		logic flag;
		w = xdp_pkg::XDP_DATA_RESET;
		// entry 0 is 10 cycles, then 8, 6, 4, 2
		for (int i = 0; i < xdp_pkg::XDP_DUMMY_ENTRIES; i++) begin
			flag = c.dummy_support[i];
			pat = c.dummy_pattern[i * xdp_pkg::XDP_DUMMY_PAT_BITS +: xdp_pkg::XDP_DUMMY_PAT_BITS];
			// an unsupported entry publishes no pattern
			if (!flag) begin
				pat = 5'h00;
			end
			w[xdp_pkg::XDP_DUMMY_FLAG_TOP - i * xdp_pkg::XDP_DUMMY_STRIDE] = flag;
			w[xdp_pkg::XDP_DUMMY_PAT_TOP - i * xdp_pkg::XDP_DUMMY_STRIDE -: xdp_pkg::XDP_DUMMY_PAT_BITS] =
				xdp_mask5(pat, c.dummy_width);
		end
		w[xdp_pkg::XDP_DUMMY_RSVD_TOP:0] = 2'h0;
		return w;
	endfunction

	function automatic logic [31:0] xdp_loc_word(
		input xdp_pkg::xdp_drv_loc_s l
	);
		logic [31:0] w;
		w = xdp_pkg::XDP_DATA_RESET;
		w[xdp_pkg::XDP_LOC_WIDTH_TOP:xdp_pkg::XDP_LOC_WIDTH_BOT] = l.width;
		// with no describable control the locator fields stay zero
		if (l.width != xdp_pkg::XDP_DRV_WIDTH_NONE) begin
			w[xdp_pkg::XDP_LOC_BYTE_SEL] = l.addr_byte1;
			w[xdp_pkg::XDP_LOC_MSB_TOP:xdp_pkg::XDP_LOC_MSB_BOT] = l.msb_pos;
			w[xdp_pkg::XDP_LOC_ADDR_TOP:xdp_pkg::XDP_LOC_ADDR_BOT] = l.reg_addr;
		end
		w[xdp_pkg::XDP_LOC_RSVD_TOP:0] = 17'h00000;
		return w;
	endfunction

	function automatic logic [31:0] xdp_type_word(
		input xdp_pkg::xdp_cfg_s c
	);
		logic [31:0] w;
		logic [1:0] dw;
		logic [2:0] pat;
		w = xdp_pkg::XDP_DATA_RESET;
		dw = xdp_drv_width(c);
		// slot 0 is the 50 ohm driver, the rest follow in type order
		for (int i = 0; i < xdp_pkg::XDP_DRV_TYPES; i++) begin
			pat = c.drv_pattern[i * xdp_pkg::XDP_DRV_PAT_BITS +: xdp_pkg::XDP_DRV_PAT_BITS];
			w[xdp_pkg::XDP_DRV_PAT_TOP - i * xdp_pkg::XDP_DRV_PAT_BITS -: xdp_pkg::XDP_DRV_PAT_BITS] =
				xdp_mask3(pat, dw);
		end
		w[xdp_pkg::XDP_DRV_RSVD_TOP:0] = 17'h00000;
		return w;
	endfunction

	// reads are refused until the straps have been captured
	assign rd_ready = (st.state == xdp_pkg::XDP_READY);
	assign rd_valid = st.rd_valid;
	assign rd_hit = st.rd_hit;
	assign rd_data = st.rd_data;

	always_comb begin
		next_st = st;
		next_st.rd_valid = 1'b0;
		case (st.state)
			xdp_pkg::XDP_CAPTURE: begin
				// straps are sampled once, on the first edge after release
				next_st.cfg = cfg;
				next_st.state = xdp_pkg::XDP_READY;
			end
			xdp_pkg::XDP_READY: begin
				if (rd_req) begin
					next_st.rd_valid = 1'b1;
					next_st.rd_hit = 1'b1;
					case (rd_index)
						xdp_pkg::XDP_WORD_DUMMY: begin
							next_st.rd_data = xdp_dummy_word(st.cfg);
						end
						xdp_pkg::XDP_WORD_DRV_VOL: begin
							next_st.rd_data = xdp_loc_word(st.cfg.drv_vol);
						end
						xdp_pkg::XDP_WORD_DRV_NVOL: begin
							next_st.rd_data = xdp_loc_word(st.cfg.drv_nvol);
						end
						xdp_pkg::XDP_WORD_DRV_TYPE: begin
							next_st.rd_data = xdp_type_word(st.cfg);
						end
						default: begin
							// words held elsewhere in the table read zero here
							next_st.rd_hit = 1'b0;
							next_st.rd_data = xdp_pkg::XDP_DATA_RESET;
						end
					endcase
				end
			end
			default: begin
				next_st.state = xdp_pkg::XDP_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ===== verification/xdp_param_words_monitor.sv
/*
 Port checker for the parameter word source.
 Assumes cfg only changes while reset is high.
*/
module xdp_param_words_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire xdp_pkg::xdp_cfg_s cfg,
	input wire logic rd_req,
	input wire logic [7:0] rd_index,
	input wire logic rd_ready,
	input wire logic rd_valid,
	input wire logic rd_hit,
	input wire logic [31:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_answer; rd_req && rd_ready |=> rd_valid; endproperty
	a_answer: assert property (p_answer) else $error("no answer after taken read");
	property p_quiet; !(rd_req && rd_ready) |=> !rd_valid && $stable(rd_data) && $stable(rd_hit); endproperty
	a_quiet: assert property (p_quiet) else $error("answer without taken read");
	property p_hit; rd_valid |-> rd_hit == ($past(rd_index) inside {[8'h0a:8'h0d]}); endproperty
	a_hit: assert property (p_hit) else $error("hit flag wrong");
	property p_miss; rd_valid && !rd_hit |-> rd_data == 32'h0; endproperty
	a_miss: assert property (p_miss) else $error("miss data not zero");
	property p_w10; rd_valid && $past(rd_index) == 8'h0a |-> rd_data[31] == cfg.dummy_support[0] && rd_data[1:0] == 2'h0; endproperty
	a_w10: assert property (p_w10) else $error("dummy word flag or low bits wrong");
	property p_rsvd; rd_valid && $past(rd_index) inside {[8'h0b:8'h0d]} |-> rd_data[16:0] == 17'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_vol; rd_valid && $past(rd_index) == 8'h0b |-> rd_data[31:30] == cfg.drv_vol.width; endproperty
	a_vol: assert property (p_vol) else $error("volatile width wrong");
	property p_nvol; rd_valid && $past(rd_index) == 8'h0c |-> rd_data[31:30] == cfg.drv_nvol.width; endproperty
	a_nvol: assert property (p_nvol) else $error("non-volatile width wrong");
	c_hit: cover property (rd_valid && rd_hit);
	c_miss: cover property (rd_valid && !rd_hit);
	c_ready: cover property ($rose(rd_ready));
endmodule
bind xdp_param_words xdp_param_words_monitor u_mon (.clk(clk), .reset(reset), .cfg(cfg), .rd_req(rd_req),
	.rd_index(rd_index), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data));

// ===== verification/xdp_host_model.sv
/*
 Table reader standing in for the host controller.
 Assumes go is a one-cycle pulse from the bench.
*/
module xdp_host_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic go,
	input wire logic [7:0] idx,
	input wire logic rd_ready,
	input wire logic rd_valid,
	input wire logic rd_hit,
	input wire logic [31:0] rd_data,
	output logic rd_req,
	output logic [7:0] rd_index,
	output logic done,
	output logic hit,
	output logic [31:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_req <= 1'b0;
			rd_index <= 8'h0;
			done <= 1'b0;
			hit <= 1'b0;
			word <= 32'h0;
		end else begin
			done <= rd_valid;
			if (go && !rd_req) begin
				rd_req <= 1'b1;
				rd_index <= idx;
			end else if (rd_req && rd_ready) begin
				rd_req <= 1'b0;
				// released index shows garbage, never the old value
				rd_index <= ~rd_index;
			end
			// host only reads; it never writes a pattern it has not located
			if (rd_valid) begin
				hit <= rd_hit;
				word <= rd_data;
			end
		end
	end
endmodule

// ===== verification/tb_top.sv
/*
 Self-checking bench for the parameter word source.
 Assumes the host model and the bound checker are compiled alongside.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset = 1'b1, go = 1'b0, rd_req, rd_ready, rd_valid, rd_hit, done, hit;
	logic [7:0] idx = 8'h0, rd_index;
	logic [31:0] rd_data, word;
	logic [95:0] r;
	xdp_pkg::xdp_cfg_s cfg = '0;
	int fails = 0, samples_checked = 0, cycles = 0;
	always #25 clk = ~clk;
	xdp_param_words u_xdp_param_words (.clk(clk), .reset(reset), .cfg(cfg), .rd_req(rd_req),
		.rd_index(rd_index), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data));
	xdp_host_model u_xdp_host_model (.clk(clk), .reset(reset), .go(go), .idx(idx), .rd_ready(rd_ready),
		.rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data), .rd_req(rd_req), .rd_index(rd_index),
		.done(done), .hit(hit), .word(word));
	function automatic logic [31:0] exp_word(xdp_pkg::xdp_cfg_s c, logic [7:0] i);
		logic [31:0] w;
		logic [2:0] dw;
		logic [1:0] tw;
		w = 32'h0;
		dw = (c.dummy_width > 3'h5) ? 3'h5 : c.dummy_width;
		tw = (c.drv_vol.width != 2'h0) ? c.drv_vol.width : c.drv_nvol.width;
		for (int k = 0; k < 5; k++) begin
			if (i == 8'h0a && c.dummy_support[k]) begin
				w[31 - 6 * k] = 1'b1;
				w[30 - 6 * k -: 5] = c.dummy_pattern[5 * k +: 5] & ((5'h1 << dw) - 5'h1);
			end
			if (i == 8'h0d)
				w[31 - 3 * k -: 3] = c.drv_pattern[3 * k +: 3] & ((3'h1 << tw) - 3'h1);
		end
		if (i == 8'h0b && c.drv_vol.width != 2'h0)
			w[31:17] = c.drv_vol;
		if (i == 8'h0c && c.drv_nvol.width != 2'h0)
			w[31:17] = c.drv_nvol;
		return w;
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(logic [7:0] i);
		int n;
		@(posedge clk) go <= 1'b1;
		idx <= i;
		@(posedge clk) go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		// a read that never answers counts against the run
		if (n == 10)
			fails++;
		@(negedge clk);
		chk(word, exp_word(cfg, i));
		chk({31'h0, hit}, {31'h0, i inside {[8'h0a:8'h0d]}});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end
	initial begin
		void'($urandom(32'h190ce1c9));
		for (int t = 0; t < 12; t++) begin
			r = {$urandom, $urandom, $urandom};
			// first tests: all ones, wide dummy width with volatile width none, zero widths
			if (t == 0)
				r = '1;
			// dummy width 7 must clamp to 5; volatile none falls back to non-volatile
			if (t == 1)
				r[47:43] = 5'h1c;
			if (t == 2) begin
				r[47:43] = 5'h00;
				r[29:28] = 2'h0;
			end
			@(posedge clk) reset <= 1'b1;
			cfg <= r[77:0];
			repeat (t == 0 ? 16 : 2) @(posedge clk);
			reset <= 1'b0;
			@(posedge clk);
			foreach (r[k]) if (k < 7) rd(k == 0 ? 8'h05 : (k == 6 ? 8'h0e : 8'h09 + 8'(k)));
			$display("test %0d done", t);
		end
		results();
	end
endmodule
